// [design/xcvr_reset_ctrl.sv]
// Purpose: Reset and power-down fan-out, lock models and calibration of a transceiver block
// Assumes: Reset and sleep requests come from fabric logic on clk_sys
// Notes: Signal-present pins are synchronised; everything else is same-domain
`timescale 1ns/1ps
`default_nettype none
module xcvr_reset_ctrl #(
  parameter int NCH = xcvr_rst_pkg::NUM_CH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [xcvr_rst_pkg::ADDR_W-1:0] addr,
  input wire logic [xcvr_rst_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [xcvr_rst_pkg::DATA_W-1:0] rd_data_q,
  input wire logic [NCH-1:0] tx_logic_rst,
  input wire logic [NCH-1:0] rx_logic_rst,
  input wire logic [NCH-1:0] rx_frontend_rst,
  input wire logic tx_pll_sleep,
  input wire logic block_sleep,
  input wire logic [NCH-1:0] force_ref_lock,
  input wire logic [NCH-1:0] force_data_lock,
  input wire logic [NCH-1:0] rx_signal_present,
  output logic clock_multiplier_unit_pd_q,
  output logic [NCH*xcvr_rst_pkg::TX_BLK_W-1:0] tx_blk_rst_q,
  output logic [NCH-1:0] tx_buf_pd_q,
  output logic [NCH*xcvr_rst_pkg::RX_BLK_W-1:0] rx_blk_rst_q,
  output logic [NCH-1:0] rx_buf_pd_q,
  output logic [NCH-1:0] cdr_hold_q,
  output logic [NCH-1:0] deser_pd_q,
  output logic [NCH-1:0] sigdet_q,
  output logic busy_q,
  output logic tx_locked_q,
  output logic [NCH-1:0] ref_locked_q,
  output logic [NCH-1:0] data_locked_q
);
  import xcvr_rst_pkg::*;

  localparam int TXL_HI = TX_PLL_LOCK_CYC + 2;

  logic [2:0] ctrl_q;
  logic oc_start_q;
  logic oc_done_pulse;
  logic oc_done_q;
  logic [CNT_W-1:0] txl_cnt_q;
  logic [NCH-1:0] sig_meta_q;
  logic [NCH-1:0] sig_sync_q;
  logic bonded_eff;
  logic [NCH-1:0] tx_eff;
  logic [NCH-1:0] rx_eff;
  logic [NCH-1:0] fe_eff;
  lock_mode_e mode_c [NCH];
  logic [DATA_W-1:0] rd_mux;

  // Lock mode from the two force inputs; data lock dominates
  function automatic lock_mode_e decode_mode(input logic f_ref, input logic f_data);
    lock_mode_e m;
    m = LOCK_AUTO;
    if (f_data) begin
      m = LOCK_MAN_DATA;
    end else if (f_ref) begin
      m = LOCK_MAN_REF;
    end
    return m;
  endfunction : decode_mode

  // XAUI forces bonding so all lanes follow channel 0 requests
  assign bonded_eff = ctrl_q[CTRL_BONDED_BIT] | ctrl_q[CTRL_XAUI_BIT];

  // Calibration engine; starts only while a receiver is configured
  offset_cancel_engine u_oc (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(ctrl_q[CTRL_RXPRES_BIT]),
    .start(oc_start_q),
    .busy_q(busy_q),
    .done_q(oc_done_pulse)
  );

  // Signal-present pins cross from the line side
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sig_meta_q <= '0;
      sig_sync_q <= '0;
    end else begin
      sig_meta_q <= rx_signal_present;
      sig_sync_q <= sig_meta_q;
    end
  end

  // Transmit PLL models lock time from sleep release
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clock_multiplier_unit_pd_q <= 1'b1;
      txl_cnt_q <= '0;
      tx_locked_q <= 1'b0;
    end else begin
      clock_multiplier_unit_pd_q <= tx_pll_sleep | block_sleep;
      if (clock_multiplier_unit_pd_q) begin
        txl_cnt_q <= '0;
        tx_locked_q <= 1'b0;
      end else if (txl_cnt_q != CNT_W'(TX_PLL_LOCK_CYC)) begin
        txl_cnt_q <= txl_cnt_q + 1'b1;
      end else begin
        tx_locked_q <= 1'b1;
      end
    end
  end

  // Per-channel reset fan-out and lock models
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam logic [CNT_W-1:0] REF_T = CNT_W'(CDR_REF_LOCK_CYC + c * CH_STAGGER_CYC);
    localparam logic [CNT_W-1:0] DATA_T = CNT_W'(CDR_DATA_LOCK_CYC + c * CH_STAGGER_CYC);
    localparam logic [CNT_W-1:0] AUTO_T = CNT_W'(REF_T + DATA_T);
    logic [CNT_W-1:0] cnt_q;
    lock_mode_e mode_q;
    logic run;

    // Bonded groups share channel 0 requests
    assign tx_eff[c] = bonded_eff ? tx_logic_rst[0] : tx_logic_rst[c];
    assign rx_eff[c] = bonded_eff ? rx_logic_rst[0] : rx_logic_rst[c];
    assign fe_eff[c] = bonded_eff ? rx_frontend_rst[0] : rx_frontend_rst[c];
    assign mode_c[c] = bonded_eff ? decode_mode(force_ref_lock[0], force_data_lock[0])
                                  : decode_mode(force_ref_lock[c], force_data_lock[c]);
    // Locks drop under front-end reset even while busy keeps the CDR alive
    assign run = ~block_sleep & ~fe_eff[c];

    // Sub-block resets and power-downs
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        tx_blk_rst_q[c*TX_BLK_W +: TX_BLK_W] <= '1;
        rx_blk_rst_q[c*RX_BLK_W +: RX_BLK_W] <= '1;
        tx_buf_pd_q[c] <= 1'b0;
        rx_buf_pd_q[c] <= 1'b0;
        deser_pd_q[c] <= 1'b0;
        cdr_hold_q[c] <= 1'b1;
        sigdet_q[c] <= 1'b0;
      end else begin
        tx_blk_rst_q[c*TX_BLK_W +: TX_BLK_W] <= {TX_BLK_W{tx_eff[c] | block_sleep}};
        rx_blk_rst_q[c*RX_BLK_W +: RX_BLK_W] <= {RX_BLK_W{rx_eff[c] | block_sleep}};
        tx_buf_pd_q[c] <= block_sleep;
        rx_buf_pd_q[c] <= block_sleep;
        deser_pd_q[c] <= block_sleep;
        cdr_hold_q[c] <= block_sleep | (fe_eff[c] & ~busy_q);
        sigdet_q[c] <= sig_sync_q[c] & ~block_sleep & (~fe_eff[c] | busy_q);
      end
    end

    // CDR model: reference lock, then data lock as the mode allows
    always_ff @(posedge clk_sys) begin
      if (reset || !run) begin
        cnt_q <= '0;
        mode_q <= LOCK_AUTO;
        ref_locked_q[c] <= 1'b0;
        data_locked_q[c] <= 1'b0;
      end else if (mode_c[c] != mode_q) begin
        mode_q <= mode_c[c];
        cnt_q <= '0;
        data_locked_q[c] <= 1'b0;
      end else begin
        if (cnt_q != AUTO_T) begin
          cnt_q <= cnt_q + 1'b1;
        end
        case (mode_q)
          LOCK_MAN_REF: begin
            ref_locked_q[c] <= (cnt_q >= REF_T);
            data_locked_q[c] <= 1'b0;
          end
          LOCK_MAN_DATA: begin
            data_locked_q[c] <= (cnt_q >= DATA_T);
          end
          LOCK_AUTO: begin
            ref_locked_q[c] <= (cnt_q >= REF_T);
            data_locked_q[c] <= (cnt_q >= AUTO_T);
          end
          default: begin
            data_locked_q[c] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Control register; the start bit is a self-clearing pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      oc_start_q <= 1'b0;
    end else begin
      oc_start_q <= wr_en && addr == ADDR_CTRL && wr_data[CTRL_OCSTART_BIT];
      if (wr_en && addr == ADDR_CTRL) begin
        ctrl_q <= wr_data[2:0];
      end
    end
  end

  // Calibration-done flag; a new completion beats a clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      oc_done_q <= 1'b0;
    end else if (oc_done_pulse) begin
      oc_done_q <= 1'b1;
    end else if (wr_en && addr == ADDR_STATUS && wr_data[ST_OCDONE_BIT]) begin
      oc_done_q <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (addr)
      ADDR_CTRL: begin
        rd_mux[2:0] = ctrl_q;
      end
      ADDR_STATUS: begin
        rd_mux[ST_BUSY_BIT] = busy_q;
        rd_mux[ST_TXLOCK_BIT] = tx_locked_q;
        rd_mux[ST_ALLREF_BIT] = &ref_locked_q;
        rd_mux[ST_ALLDATA_BIT] = &data_locked_q;
        rd_mux[ST_OCDONE_BIT] = oc_done_q;
      end
      ADDR_LOCKS: begin
        rd_mux[NCH-1:0] = ref_locked_q;
        rd_mux[LOCKS_DATA_POS +: NCH] = data_locked_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_en ? rd_mux : '0;
    end
  end

  tx_scope_a: assert property (@(posedge clk_sys) disable iff (reset)
    tx_eff[0] && !rx_eff[0] && !block_sleep |=>
      &tx_blk_rst_q[TX_BLK_W-1:0] && rx_blk_rst_q[RX_BLK_W-1:0] == '0 && !tx_buf_pd_q[0])
    else $error("transmit reset reached the wrong blocks");
  rx_scope_a: assert property (@(posedge clk_sys) disable iff (reset)
    rx_eff[0] && !tx_eff[0] && !block_sleep |=>
      &rx_blk_rst_q[RX_BLK_W-1:0] && !deser_pd_q[0] && tx_blk_rst_q[TX_BLK_W-1:0] == '0)
    else $error("receive reset reached the wrong blocks");
  pll_sleep_a: assert property (@(posedge clk_sys) disable iff (reset)
    tx_pll_sleep && !block_sleep |=> clock_multiplier_unit_pd_q && !rx_buf_pd_q[0]
      && !tx_buf_pd_q[0] && !deser_pd_q[0]) else $error("PLL sleep too wide");
  block_sleep_a: assert property (@(posedge clk_sys) disable iff (reset)
    block_sleep |=> clock_multiplier_unit_pd_q && &tx_buf_pd_q && &rx_buf_pd_q
      && &deser_pd_q && &cdr_hold_q) else $error("block sleep incomplete");
  sigdet_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
    busy_q && !block_sleep && sig_sync_q[0] |=> sigdet_q[0] && !cdr_hold_q[0])
    else $error("busy did not override front-end reset");
  fe_lock_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
    fe_eff[0] |=> !ref_locked_q[0] && !data_locked_q[0]) else $error("lock kept in reset");
  tx_lock_time_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(clock_multiplier_unit_pd_q) |-> ##[1:TXL_HI] (tx_locked_q || clock_multiplier_unit_pd_q))
    else $error("transmit PLL did not lock");
  ref_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    mode_c[0] == LOCK_MAN_REF && $past(mode_c[0]) == LOCK_MAN_REF |=> !data_locked_q[0])
    else $error("data lock in reference mode");
  xaui_bond_a: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_q[CTRL_XAUI_BIT] && tx_logic_rst[0] |=> &tx_blk_rst_q)
    else $error("XAUI lanes not bonded");
endmodule : xcvr_reset_ctrl
`default_nettype wire

// [include/xcvr_rst_pkg.sv]
// Purpose: Shared constants for the transceiver reset and power-down block
// Assumes: 40 MHz system clock, four channels per transceiver block
// Notes: Lock and calibration times model the analog parts of the block
package xcvr_rst_pkg;
  // Clock and channel figures
  localparam int CLK_PERIOD_PS = 25000;
  localparam int NUM_CH = 4;
  localparam int TX_BLK_W = 5;
  localparam int RX_BLK_W = 8;
  localparam int CNT_W = 12;
  // Modelled lock times in ns and their cycle counts, rounded up
  localparam int TX_PLL_LOCK_NS = 2000;
  localparam int CDR_REF_LOCK_NS = 3000;
  localparam int CDR_DATA_LOCK_NS = 2500;
  localparam int CH_STAGGER_NS = 250;
  localparam int TX_PLL_LOCK_CYC = (TX_PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CDR_REF_LOCK_CYC = (CDR_REF_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CDR_DATA_LOCK_CYC = (CDR_DATA_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CH_STAGGER_CYC = (CH_STAGGER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Reconfiguration clock as an enable, and calibration length in its cycles
  localparam int RECONF_DIV = 4;
  localparam int OC_RECONF_CYCLES = 64;
  // Register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_LOCKS = 4'h8;
  // Control fields
  localparam int CTRL_XAUI_BIT = 0;
  localparam int CTRL_BONDED_BIT = 1;
  localparam int CTRL_RXPRES_BIT = 2;
  localparam int CTRL_OCSTART_BIT = 3;
  localparam logic [2:0] CTRL_RESET = 3'h6;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TXLOCK_BIT = 1;
  localparam int ST_ALLREF_BIT = 2;
  localparam int ST_ALLDATA_BIT = 3;
  localparam int ST_OCDONE_BIT = 4;
  // Lock field: data locks sit above reference locks
  localparam int LOCKS_DATA_POS = 8;
  // Receiver clock-data recovery lock modes
  typedef enum logic [1:0] {LOCK_AUTO, LOCK_MAN_REF, LOCK_MAN_DATA} lock_mode_e;
endpackage : xcvr_rst_pkg

// [design/offset_cancel_engine.sv]
// Purpose: Receiver offset-cancellation sequencer with its busy handshake
// Assumes: Reconfiguration clock is an enable, one pulse per RECONF_DIV cycles
// Notes: Starts by itself after reset whenever a receiver is present
`timescale 1ns/1ps
`default_nettype none
module offset_cancel_engine (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic start,
  output logic busy_q,
  output logic done_q
);
  import xcvr_rst_pkg::*;

  typedef enum logic [1:0] {OC_ARM, OC_FIRST, OC_RUN, OC_IDLE} oc_state_e;
  localparam int DIV_W = $clog2(RECONF_DIV);
  localparam int OC_W = $clog2(OC_RECONF_CYCLES);
  localparam int ARM_HI = RECONF_DIV + 2;

  oc_state_e state_q;
  logic [DIV_W-1:0] div_q;
  logic [OC_W-1:0] oc_cnt_q;
  logic tick;

  assign tick = (div_q == DIV_W'(RECONF_DIV - 1));

  // Divider restarts on entry so the first reconfig cycle is whole
  always_ff @(posedge clk_sys) begin
    if (reset || state_q == OC_ARM || state_q == OC_IDLE) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // Busy low for one reconfig cycle, then high until calibration ends
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= OC_ARM;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      oc_cnt_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        OC_ARM: begin
          if (enable) begin
            state_q <= OC_FIRST;
          end
        end
        OC_FIRST: begin
          if (tick) begin
            state_q <= OC_RUN;
            busy_q <= 1'b1;
            oc_cnt_q <= '0;
          end
        end
        OC_RUN: begin
          if (tick) begin
            oc_cnt_q <= oc_cnt_q + 1'b1;
            if (oc_cnt_q == OC_W'(OC_RECONF_CYCLES - 1)) begin
              state_q <= OC_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
        OC_IDLE: begin
          if (start && enable) begin
            state_q <= OC_FIRST;
          end
        end
        default: begin
          state_q <= OC_ARM;
        end
      endcase
    end
  end

  first_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == OC_FIRST |-> !busy_q) else $error("busy high in first reconfig cycle");
  busy_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == OC_FIRST && tick |=> busy_q [*8]) else $error("busy did not hold");
  oc_enable_a: assert property (@(posedge clk_sys) disable iff (reset)
    state_q == OC_ARM && enable |-> ##[1:ARM_HI] busy_q) else $error("calibration not started");
  done_mark_a: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(busy_q) |-> done_q) else $error("busy fell without done");
endmodule : offset_cancel_engine
`default_nettype wire

// [tb/reset_user_model.sv]
// Purpose: Fabric reset controller model for the transceiver block
// Assumes: Bonded group, every channel bit driven alike
// Notes: Waits counted in clk_sys cycles; go starts one power-up sequence
`timescale 1ns/1ps
`default_nettype none
module reset_user_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic manual,
  input wire logic busy_q,
  input wire logic tx_locked_q,
  input wire logic [xcvr_rst_pkg::NUM_CH-1:0] ref_locked_q,
  input wire logic [xcvr_rst_pkg::NUM_CH-1:0] data_locked_q,
  output logic [xcvr_rst_pkg::NUM_CH-1:0] tx_logic_rst,
  output logic [xcvr_rst_pkg::NUM_CH-1:0] rx_logic_rst,
  output logic [xcvr_rst_pkg::NUM_CH-1:0] rx_frontend_rst,
  output logic tx_pll_sleep,
  output logic [xcvr_rst_pkg::NUM_CH-1:0] force_ref_lock,
  output logic [xcvr_rst_pkg::NUM_CH-1:0] force_data_lock,
  output logic tx_ready,
  output logic rx_ready
);
  import xcvr_rst_pkg::*;
  localparam int US_CYC = 1000000 / CLK_PERIOD_PS;

  // One sequencer; all resets held from time zero, far longer than two cycles
  initial begin
    {tx_logic_rst, rx_logic_rst, rx_frontend_rst} = '1;
    tx_pll_sleep = 1'b1;
    force_ref_lock = '0;
    force_data_lock = '0;
    tx_ready = 1'b0;
    rx_ready = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        // Whole group moves together so bonded lanes stay aligned
        tx_logic_rst <= '1;
        rx_logic_rst <= '1;
        rx_frontend_rst <= '1;
        tx_pll_sleep <= 1'b1;
        force_ref_lock <= {NUM_CH{manual}};
        force_data_lock <= '0;
        tx_ready <= 1'b0;
        rx_ready <= 1'b0;
        repeat (US_CYC) @(posedge clk_sys);
        tx_pll_sleep <= 1'b0;
        while (tx_locked_q !== 1'b1) @(posedge clk_sys);
        tx_logic_rst <= '0;
        tx_ready <= 1'b1;
        // Calibration launched by reset is still running here
        while (busy_q !== 1'b0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        rx_frontend_rst <= '0;
        if (manual) begin
          while (&ref_locked_q !== 1'b1) @(posedge clk_sys);
          repeat (15 * US_CYC) @(posedge clk_sys);
          force_ref_lock <= '0;
          force_data_lock <= '1;
        end else begin
          while (&data_locked_q !== 1'b1) @(posedge clk_sys);
        end
        repeat (4 * US_CYC) @(posedge clk_sys);
        rx_logic_rst <= '0;
        rx_ready <= 1'b1;
      end
    end
  end
endmodule : reset_user_model
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the transceiver reset and power-down block
// Assumes: Bonded group of four; partner model runs the power-up sequence
// Notes: Bench can take over the transmit reset to probe channel bonding
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import xcvr_rst_pkg::*;
  localparam int N = NUM_CH;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic block_sleep = 1'b0;
  logic go = 1'b0;
  logic manual = 1'b1;
  logic own = 1'b0;
  logic [N-1:0] tb_tx_rst = '0;
  logic [N-1:0] rx_signal_present = '1;
  logic [DATA_W-1:0] rd_data_q;
  logic [N-1:0] p_tx_rst, tx_logic_rst, rx_logic_rst, rx_frontend_rst;
  logic [N-1:0] force_ref_lock, force_data_lock, tx_buf_pd_q, rx_buf_pd_q;
  logic [N-1:0] cdr_hold_q, deser_pd_q, sigdet_q, ref_locked_q, data_locked_q;
  logic [N*TX_BLK_W-1:0] tx_blk_rst_q;
  logic [N*RX_BLK_W-1:0] rx_blk_rst_q;
  logic tx_pll_sleep, clock_multiplier_unit_pd_q, busy_q, tx_locked_q, tx_ready, rx_ready;
  int fail_count = 0;
  int comparisons = 0;

  always #12.5 clk_sys = ~clk_sys;
  // Bench override used only for the bonding probe
  assign tx_logic_rst = own ? tb_tx_rst : p_tx_rst;

  xcvr_reset_ctrl #(.NCH(N)) xcvr_reset_ctrl_inst (.clk_sys, .reset, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data_q, .tx_logic_rst, .rx_logic_rst, .rx_frontend_rst,
    .tx_pll_sleep, .block_sleep, .force_ref_lock, .force_data_lock, .rx_signal_present,
    .clock_multiplier_unit_pd_q, .tx_blk_rst_q, .tx_buf_pd_q, .rx_blk_rst_q, .rx_buf_pd_q,
    .cdr_hold_q, .deser_pd_q, .sigdet_q, .busy_q, .tx_locked_q, .ref_locked_q,
    .data_locked_q);

  reset_user_model reset_user_model_inst (.clk_sys, .go, .manual, .busy_q, .tx_locked_q,
    .ref_locked_q, .data_locked_q, .tx_logic_rst(p_tx_rst), .rx_logic_rst,
    .rx_frontend_rst, .tx_pll_sleep, .force_ref_lock, .force_data_lock, .tx_ready,
    .rx_ready);

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  // Extra idle edge so back-to-back writes never re-drive the strobe in one step
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    // Look while the read data stand, not at the edge that clears them
    @(negedge clk_sys);
    chk(rd_data_q, exp);
    @(posedge clk_sys);
  endtask : reg_rd

  function automatic logic pick(input int s);
    case (s)
      0: return busy_q;
      1: return clock_multiplier_unit_pd_q;
      2: return tx_locked_q;
      3: return tx_ready;
      4: return &ref_locked_q;
      default: return rx_ready;
    endcase
  endfunction : pick

  // Bounded wait; a hang ends the run through the closing report
  task automatic wait_sig(input int s, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (pick(s) !== lvl) begin
      fail_count++;
      $display("CHECK FAILED at %0t: wait %0d timed out", $time, s);
      test_done();
    end
  endtask : wait_sig

  initial begin : main
    int n;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    go <= 1'b1;
    #1 chk(busy_q, 1'b0);
    @(posedge clk_sys);
    go <= 1'b0;
    reg_rd(ADDR_CTRL, 32'h0000_0006);
    reg_rd(4'hC, 32'h0000_0000);
    wait_sig(0, 1'b1, 10, n);
    repeat (4) @(posedge clk_sys);
    chk(clock_multiplier_unit_pd_q, 1'b1);
    chk({tx_buf_pd_q, rx_buf_pd_q, deser_pd_q}, 0);
    chk(tx_blk_rst_q, {(N*TX_BLK_W){1'b1}});
    chk(rx_blk_rst_q, {(N*RX_BLK_W){1'b1}});
    chk({cdr_hold_q, sigdet_q}, {{N{1'b0}}, {N{1'b1}}});
    reg_rd(ADDR_STATUS, 32'h0000_0001);
    wait_sig(1, 1'b0, 60, n);
    wait_sig(2, 1'b1, 100, n);
    chk(n >= 80 && n <= 82, 1'b1);
    wait_sig(3, 1'b1, 10, n);
    @(posedge clk_sys);
    chk(tx_blk_rst_q, 0);
    chk(rx_blk_rst_q, {(N*RX_BLK_W){1'b1}});
    wait_sig(0, 1'b0, 300, n);
    #1 chk({cdr_hold_q, sigdet_q}, {{N{1'b1}}, {N{1'b0}}});
    wait_sig(4, 1'b1, 400, n);
    repeat (300) @(posedge clk_sys);
    chk(data_locked_q, 0);
    wait_sig(5, 1'b1, 1000, n);
    @(posedge clk_sys);
    chk({ref_locked_q, data_locked_q}, {(2*N){1'b1}});
    chk(rx_blk_rst_q, 0);
    reg_rd(ADDR_LOCKS, 32'h0000_0F0F);
    reg_rd(ADDR_STATUS, 32'h0000_001E);
    reg_wr(ADDR_STATUS, 32'h0000_0010);
    reg_rd(ADDR_STATUS, 32'h0000_000E);
    // Lane 1 request alone: only a non-bonded, non-XAUI group obeys it
    own <= 1'b1;
    tb_tx_rst <= N'(2);
    repeat (2) @(posedge clk_sys);
    chk(tx_blk_rst_q, 0);
    reg_wr(ADDR_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk_sys);
    chk(tx_blk_rst_q, 32'h0000_03E0);
    reg_wr(ADDR_CTRL, 32'h0000_0005);
    repeat (2) @(posedge clk_sys);
    chk(tx_blk_rst_q, 0);
    // Lane 0 request under XAUI must reach all four lanes
    tb_tx_rst <= N'(1);
    repeat (2) @(posedge clk_sys);
    chk(tx_blk_rst_q, {(N*TX_BLK_W){1'b1}});
    own <= 1'b0;
    reg_wr(ADDR_CTRL, 32'h0000_0002);
    reg_wr(ADDR_CTRL, 32'h0000_000A);
    repeat (8) @(posedge clk_sys);
    chk(busy_q, 1'b0);
    reg_wr(ADDR_CTRL, 32'h0000_000E);
    #1 chk(busy_q, 1'b0);
    wait_sig(0, 1'b1, 10, n);
    wait_sig(0, 1'b0, 300, n);
    chk(n >= 255 && n <= 257, 1'b1);
    block_sleep <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({clock_multiplier_unit_pd_q, tx_buf_pd_q, rx_buf_pd_q, deser_pd_q, cdr_hold_q},
        {(4*N+1){1'b1}});
    chk({sigdet_q, ref_locked_q, data_locked_q}, 0);
    block_sleep <= 1'b0;
    // Second reset in mid-run, then the automatic lock sequence
    reset <= 1'b1;
    manual <= 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    reg_rd(ADDR_CTRL, 32'h0000_0006);
    wait_sig(5, 1'b1, 1200, n);
    @(posedge clk_sys);
    chk(data_locked_q, {N{1'b1}});
    chk({tx_blk_rst_q, rx_blk_rst_q}, 0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
